/* File: src/scd_pkg.sv */
// Package with register map, configuration layout and types of the clock select and divider block.
package scd_pkg;

    // Printed offsets are register indices; byte address is four times the index.
    localparam logic [9:0] SCD_DIVIDER_IDX = 10'h095;
    localparam logic [9:0] SCD_CONFIG_IDX = 10'h096;
    localparam logic [9:0] SCD_STATUS_IDX = 10'h097;

    localparam logic [7:0] SCD_DIVIDER_RST = 8'h00;
    localparam logic [7:0] SCD_CONFIG_RST = 8'hff;

    localparam int SCD_SRC_LSB = 0;
    localparam int SCD_RCFS_BIT = 3;
    localparam int SCD_FILT_BIT = 4;
    localparam int SCD_WDT_BIT = 7;

    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        SCD_SRC_EXT_CLK,
        SCD_SRC_CRYSTAL,
        SCD_SRC_RESERVED,
        SCD_SRC_RC_OSC
    } scd_src_type;

    // Layout of the clock configuration byte, bit 7 down to bit 0.
    typedef struct packed {
        logic watchdog_config_enable;
        logic [1:0] rsv_hi;
        logic crystal_input_filter_enable;
        logic rc_frequency_select;
        logic rsv_lo;
        scd_src_type clock_source_select;
    } scd_cfg_type;

    // Oscillator source levels, sampled on the core clock.
    typedef struct packed {
        logic rc_osc;
        logic crystal_input_pin;
    } scd_osc_type;

endpackage : scd_pkg

/* File: src/scd_clock_select.sv */
// System clock source selection, crystal input filter and system clock divider with AXI4-Lite registers.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module scd_clock_select
    import scd_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // Programmed configuration byte
    input wire logic [7:0] i_clock_config_byte,
    // Oscillator levels
    input wire scd_osc_type i_osc,
    // Crystal amplifier output pin
    output logic o_crystal_output_pin,
    output logic o_crystal_output_pin_oe,
    // System clock
    output logic o_sys_clk,
    // AXI4-Lite write channels
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read channels
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);

    initial begin
        if (ADDR_W < 12 || ADDR_W > 32) begin
            $error("ADDR_W must be between 12 and 32");
        end
    end

    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction : rise

    function automatic logic [9:0] word_idx(input logic [ADDR_W-1:0] addr);
        word_idx = addr[11:2];
    endfunction : word_idx

    scd_cfg_type cfg_reg;
    logic cfg_loaded_reg;
    logic [7:0] divider_reg;
    logic rc_prev_reg;
    logic rc_half_reg;
    logic [1:0] xtal_hist_reg;
    logic xtal_filt_reg;
    logic osc_lvl;
    logic osc_prev_reg;
    logic [7:0] div_cnt_reg;
    logic sys_clk_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [9:0] aw_idx_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic awready_reg;
    logic wready_reg;
    logic arready_reg;

    // Programmed bits are caught once after reset release, never from the port under reset.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cfg_reg <= scd_cfg_type'(SCD_CONFIG_RST);
            cfg_loaded_reg <= 1'b0;
        end else if (!cfg_loaded_reg) begin
            cfg_reg <= scd_cfg_type'(i_clock_config_byte);
            cfg_loaded_reg <= 1'b1;
        end
    end

    // Half-rate RC path toggles on each RC rising edge.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            rc_prev_reg <= 1'b0;
            rc_half_reg <= 1'b0;
        end else begin
            rc_prev_reg <= i_osc.rc_osc;
            if (rise(rc_prev_reg, i_osc.rc_osc)) begin
                rc_half_reg <= ~rc_half_reg;
            end
        end
    end

    // The filter trades two extra cycles of latency for rejecting single-sample glitches.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            xtal_hist_reg <= 2'b00;
            xtal_filt_reg <= 1'b0;
        end else begin
            xtal_hist_reg <= {xtal_hist_reg[0], i_osc.crystal_input_pin};
            if (!cfg_reg.crystal_input_filter_enable) begin
                xtal_filt_reg <= i_osc.crystal_input_pin;
            end else if (xtal_hist_reg[1] == xtal_hist_reg[0]) begin
                xtal_filt_reg <= xtal_hist_reg[0];
            end
        end
    end

    // Reserved source code gives no clock rather than guessing a source.
    always_comb begin
        case (cfg_reg.clock_source_select)
            SCD_SRC_RC_OSC: osc_lvl = cfg_reg.rc_frequency_select ? rc_prev_reg : rc_half_reg;
            SCD_SRC_CRYSTAL: osc_lvl = xtal_filt_reg;
            SCD_SRC_EXT_CLK: osc_lvl = xtal_filt_reg;
            SCD_SRC_RESERVED: osc_lvl = 1'b0;
            default: osc_lvl = 1'b0;
        endcase
    end

    // Inverting amplifier drives the crystal output pin only in crystal mode.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_crystal_output_pin <= 1'b0;
            o_crystal_output_pin_oe <= 1'b0;
        end else begin
            o_crystal_output_pin <= ~i_osc.crystal_input_pin;
            o_crystal_output_pin_oe <= (cfg_reg.clock_source_select == SCD_SRC_CRYSTAL);
        end
    end

    // Divider toggles every N+1 oscillator rising edges, a period of 2*(N+1); N of 0 passes the oscillator level straight through.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            osc_prev_reg <= 1'b0;
            div_cnt_reg <= 8'h00;
            sys_clk_reg <= 1'b0;
        end else begin
            osc_prev_reg <= osc_lvl;
            if (divider_reg == 8'h00) begin
                sys_clk_reg <= osc_lvl;
                div_cnt_reg <= 8'h00;
            end else if (rise(osc_prev_reg, osc_lvl)) begin
                if (div_cnt_reg >= divider_reg) begin
                    div_cnt_reg <= 8'h00;
                    sys_clk_reg <= ~sys_clk_reg;
                end else begin
                    div_cnt_reg <= div_cnt_reg + 8'h01;
                end
            end
        end
    end

    assign o_sys_clk = sys_clk_reg;

    // Write path: address and data are taken in either order, response after both.
    // Readies are registered so that every bus output comes from a flip-flop.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_idx_reg <= 10'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= AXI_OKAY;
            divider_reg <= SCD_DIVIDER_RST;
        end else begin
            if (i_awvalid && awready_reg) begin
                aw_got_reg <= 1'b1;
                awready_reg <= 1'b0;
                aw_idx_reg <= word_idx(i_awaddr);
            end
            if (i_wvalid && wready_reg) begin
                w_got_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
            end
            if (aw_got_reg && w_got_reg && !bvalid_reg) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                if (aw_idx_reg == SCD_DIVIDER_IDX) begin
                    bresp_reg <= AXI_OKAY;
                    if (wstrb_reg[0]) begin
                        divider_reg <= wdata_reg[7:0];
                    end
                end else begin
                    bresp_reg <= AXI_SLVERR;
                end
            end else if (bvalid_reg && i_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    assign o_awready = awready_reg;
    assign o_wready = wready_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;

    // Read path answers one cycle after the address is taken.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= AXI_OKAY;
        end else if (i_arvalid && arready_reg) begin
            rvalid_reg <= 1'b1;
            arready_reg <= 1'b0;
            rresp_reg <= AXI_OKAY;
            case (word_idx(i_araddr))
                SCD_DIVIDER_IDX: rdata_reg <= {24'h00_0000, divider_reg};
                SCD_CONFIG_IDX: rdata_reg <= {24'h00_0000, cfg_reg};
                SCD_STATUS_IDX: rdata_reg <= {29'h0000_0000, cfg_loaded_reg, sys_clk_reg, osc_prev_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= AXI_SLVERR;
                end
            endcase
        end else if (rvalid_reg && i_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    assign o_arready = arready_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;

endmodule : scd_clock_select

/* File: tb/scd_monitor.sv */
// Checker for bus handshakes and clock path outputs of the clock select block.
`timescale 1ns/10ps
module scd_monitor
    import scd_pkg::*;
(
    // Clock, reset, configuration and oscillators
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_clock_config_byte,
    input wire scd_osc_type i_osc,
    // Outputs and bus
    input wire logic o_crystal_output_pin,
    input wire logic o_crystal_output_pin_oe,
    input wire logic o_sys_clk,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read not answered");
    a_resp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    a_busy_refuse: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write taken while busy");
    a_xout_inverse: assert property (o_crystal_output_pin_oe && !$past(i_srst) |->
        o_crystal_output_pin == !$past(i_osc.crystal_input_pin)) else $error("amplifier output wrong");
    a_oe_crystal: assert property (o_crystal_output_pin_oe |-> i_clock_config_byte[1:0] == 2'b01)
        else $error("amplifier driven off crystal mode");
    a_reserved_idle: assert property (i_clock_config_byte[1:0] == 2'b10 |-> !o_sys_clk)
        else $error("reserved source gives clock");
    cover property (o_bvalid && i_bready && o_bresp == AXI_SLVERR);
    cover property (o_rvalid && i_rready);
    cover property ($rose(o_sys_clk));
endmodule : scd_monitor

bind scd_clock_select scd_monitor u_mon (.*);

/* File: tb/tb_scd_clock_select.sv */
// Self-checking bench for the clock select and divider block.
`timescale 1ns/10ps
module tb_scd_clock_select
    import scd_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [7:0] cfg = 8'hff;
    scd_osc_type osc = '0;
    logic xo, xoe, sclk, awrdy, wrdy, bv, arrdy, rv;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] wd = 32'h0, rd;
    logic [3:0] ws = 4'h0;
    logic [1:0] bresp, rresp;
    int num_errors = 0;
    int tests_run = 0;
    int oc = 0;
    always #20 i_core_clk = ~i_core_clk;
    // Both oscillators run well below half the core rate, as the sampling input stage needs.
    always @(posedge i_core_clk) begin
        oc <= oc + 1;
        if (oc % 4 == 3) osc.rc_osc <= ~osc.rc_osc;
        if (oc % 6 == 5) osc.crystal_input_pin <= ~osc.crystal_input_pin;
    end
    scd_clock_select dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_clock_config_byte(cfg), .i_osc(osc),
        .o_crystal_output_pin(xo), .o_crystal_output_pin_oe(xoe), .o_sys_clk(sclk), .i_awvalid(awv),
        .o_awready(awrdy), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd), .i_wstrb(ws),
        .o_bvalid(bv), .i_bready(br), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arrdy), .i_araddr(ara),
        .o_rvalid(rv), .i_rready(rr), .o_rdata(rd), .o_rresp(rresp));
    task tally_and_finish;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task rst(input logic [7:0] c);
        i_srst <= 1'b1;
        cfg <= c;
        repeat (20) @(posedge i_core_clk);
        i_srst <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    endtask : rst
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= d;
        ws <= s;
        br <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge i_core_clk);
            if (awv && awrdy) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bv && br) break;
        end
        r = bresp;
        br <= 1'b0;
        @(posedge i_core_clk);
        if (n == 40) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : wr
    task rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        arv <= 1'b1;
        ara <= a;
        rr <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge i_core_clk);
            if (arv && arrdy) arv <= 1'b0;
            if (rv && rr) break;
        end
        d = rd;
        r = rresp;
        rr <= 1'b0;
        @(posedge i_core_clk);
        if (n == 40) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : rdr
    // Measures the spacing of the last two of three system clock rises; a stopped clock gives zero.
    task per(output int p);
        int n, last, k;
        logic q;
        p = 0;
        k = 0;
        last = 0;
        q = sclk;
        for (n = 0; n < 700 && k < 3; n++) begin
            @(negedge i_core_clk);
            if (sclk && !q) begin
                if (k > 0) p = n - last;
                last = n;
                k++;
            end
            q = sclk;
        end
        @(posedge i_core_clk);
    endtask : per
    // Counts core cycles from a crystal pin rise to the following system clock rise.
    task lat(output int l);
        int n;
        logic q;
        l = 0;
        q = 1'b1;
        for (n = 0; n < 100 && !(osc.crystal_input_pin && !q); n++) begin
            q = osc.crystal_input_pin;
            @(negedge i_core_clk);
        end
        for (n = 0; n < 100 && !sclk; n++) begin
            @(negedge i_core_clk);
            l++;
        end
        @(posedge i_core_clk);
    endtask : lat
    task sc_regs;
        logic [31:0] d;
        logic [1:0] r;
        rst(8'hff);
        rdr(12'h254, d, r);
        check("divider reset", d, 32'h0);
        check("divider rresp", {30'h0, r}, {30'h0, AXI_OKAY});
        wr(12'h254, 32'h1ab, 4'hf, r);
        check("divider wresp", {30'h0, r}, {30'h0, AXI_OKAY});
        wr(12'h254, 32'h12, 4'h0, r);
        rdr(12'h254, d, r);
        check("divider value", d, 32'hab);
        wr(12'h258, 32'h0, 4'hf, r);
        check("config wresp", {30'h0, r}, {30'h0, AXI_SLVERR});
        rdr(12'h258, d, r);
        check("config value", d, 32'hff);
        rdr(12'h25c, d, r);
        check("status loaded", {31'h0, d[2]}, 32'h1);
        rdr(12'h300, d, r);
        check("unmapped data", d, 32'h0);
        check("unmapped resp", {30'h0, r}, {30'h0, AXI_SLVERR});
    endtask : sc_regs
    task sc_sources;
        logic [7:0] c [6] = '{8'hff, 8'hf7, 8'hfd, 8'hed, 8'hfc, 8'hfe};
        int e [6] = '{8, 16, 12, 12, 12, 0};
        int p;
        for (int i = 0; i < 6; i++) begin
            rst(c[i]);
            per(p);
            check("source period", p, e[i]);
            check("amplifier enable", {31'h0, xoe}, {31'h0, c[i][1:0] == 2'b01});
            if (!c[i][1]) begin
                lat(p);
                check("filter latency", p, c[i][4] ? 4 : 2);
            end
        end
    endtask : sc_sources
    task sc_divider;
        logic [1:0] r;
        int p;
        rst(8'hff);
        for (int k = 2; k >= 0; k--) begin
            wr(12'h254, k, 4'hf, r);
            per(p);
            check("divided period", p, (k == 0) ? 8 : 16 * (k + 1));
        end
    endtask : sc_divider
    initial begin
        sc_regs();
        sc_sources();
        sc_divider();
        tally_and_finish();
    end
endmodule : tb_scd_clock_select
